// *** logic/ccp_top.sv ***
// two-unit capture/compare/pwm control block behind an ahb-lite slave
`timescale 1ns/1ns
`default_nettype none

module ccp_top
  import ccp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  input wire logic [CCP_UNITS-1:0] capture_pin,
  input wire logic [CCP_VALUE_W-1:0] timer_one_count,
  input wire logic adc_enabled,
  output logic [CCP_UNITS-1:0] compare_out,
  output logic timer_one_reset,
  output logic adc_start,
  output ccp_pwm_t [CCP_UNITS-1:0] pwm
);

  // ****************************************
  // declarations
  // ****************************************
  ccp_top_state_t st_reg;
  ccp_top_state_t st_next;
  ccp_evt_t [CCP_UNITS-1:0] evt;
  logic take;
  logic mapped;
  logic [CCP_IDX_W-1:0] addr_idx;
  logic [CCP_UNITS-1:0] pwm_mode;
  logic [CCP_UNITS-1:0] special_hit;

  // ****************************************
  // read mux
  // ****************************************
  // built from the next state, so a read right after a write sees it
  function automatic logic [31:0] read_word(
    input ccp_top_state_t s,
    input logic [CCP_IDX_W-1:0] idx
  );
    logic [31:0] w;
    w = CCP_RDATA_ZERO;
    case (idx)
      CCP_IDX_CTRL1: begin
        w[CCP_CTRL_W-1:0] = s.ctrl[0];
      end
      CCP_IDX_CTRL2: begin
        w[CCP_CTRL_W-1:0] = s.ctrl[1];
      end
      CCP_IDX_VAL1_LO: begin
        w[7:0] = s.value[0][7:0];
      end
      CCP_IDX_VAL1_HI: begin
        w[7:0] = s.value[0][15:8];
      end
      CCP_IDX_VAL2_LO: begin
        w[7:0] = s.value[1][7:0];
      end
      CCP_IDX_VAL2_HI: begin
        w[7:0] = s.value[1][15:8];
      end
      CCP_IDX_FLAGS: begin
        w[CCP_FLAG_POS1] = s.flag[0];
        w[CCP_FLAG_POS2] = s.flag[1];
      end
      default: begin
        w = CCP_RDATA_ZERO;
      end
    endcase
    return w;
  endfunction

  // ****************************************
  // address phase decode
  // ****************************************
  // only whole-word singles are expected; hsize is not checked
  assign take = hsel & hready & htrans[1];
  assign mapped = (haddr[31:10] == CCP_ADDR_HI_ZERO);
  assign addr_idx = haddr[9:2];

  // pwm mode per unit, used to lock the value high byte
  always_comb begin
    for (int u = 0; u < CCP_UNITS; u++) begin
      pwm_mode[u] = (st_reg.ctrl[u][3:2] == CCP_GRP_PWM);
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;

    // data phase of a write: store the byte in its register
    if (st_reg.wr_pend) begin
      case (st_reg.wr_idx)
        CCP_IDX_CTRL1: begin
          st_next.ctrl[0] = hwdata[CCP_CTRL_W-1:0];
        end
        CCP_IDX_CTRL2: begin
          st_next.ctrl[1] = hwdata[CCP_CTRL_W-1:0];
        end
        CCP_IDX_VAL1_LO: begin
          st_next.value[0][7:0] = hwdata[7:0];
        end
        CCP_IDX_VAL1_HI: begin
          if (!pwm_mode[0]) begin
            st_next.value[0][15:8] = hwdata[7:0];
          end
        end
        CCP_IDX_VAL2_LO: begin
          st_next.value[1][7:0] = hwdata[7:0];
        end
        CCP_IDX_VAL2_HI: begin
          if (!pwm_mode[1]) begin
            st_next.value[1][15:8] = hwdata[7:0];
          end
        end
        CCP_IDX_FLAGS: begin
          // writing zero clears a flag; software may also set one
          st_next.flag[0] = hwdata[CCP_FLAG_POS1];
          st_next.flag[1] = hwdata[CCP_FLAG_POS2];
        end
        default: begin
          st_next.wr_pend = st_reg.wr_pend;
        end
      endcase
    end

    // hardware events come last, so they win over a bus write
    for (int u = 0; u < CCP_UNITS; u++) begin
      if (evt[u].capture) begin
        // no read guard: an unread value is simply replaced
        st_next.value[u] = timer_one_count;
      end
      if (evt[u].event_hit) begin
        // a mode change can cause a stray edge; flag still sticks
        st_next.flag[u] = 1'b1;
      end
    end

    // address phase: latch write target, fetch read data now
    st_next.wr_pend = take & hwrite & mapped;
    st_next.wr_idx = addr_idx;
    if (take & !hwrite) begin
      if (mapped) begin
        st_next.rdata = read_word(st_next, addr_idx);
      end else begin
        st_next.rdata = CCP_RDATA_ZERO;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // engines, one per unit
  // ****************************************
  generate
    for (genvar g = 0; g < CCP_UNITS; g++) begin : gen_unit
      ccp_unit u_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .capture_pin(capture_pin[g]),
        .unit_mode_field(st_reg.ctrl[g][3:0]),
        .compare_value(st_reg.value[g]),
        .timer_one_count(timer_one_count),
        .evt(evt[g]),
        .compare_out(compare_out[g])
      );
      assign special_hit[g] = evt[g].special;
      // both pwm units run from the one timer-two base outside
      assign pwm[g].active = pwm_mode[g];
      assign pwm[g].duty = {st_reg.value[g][7:0], st_reg.ctrl[g][5:4]};
    end
  endgenerate

  // ****************************************
  // special event trigger
  // ****************************************
  // either unit clears timer one; only the second may start a conversion
  assign timer_one_reset = |special_hit;
  assign adc_start = special_hit[1] & adc_enabled;

  // ****************************************
  // bus answers
  // ****************************************
  // zero wait states: every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hrdata = st_reg.rdata;
  assign hresp = CCP_HRESP_OKAY;

endmodule
`default_nettype wire

// *** logic/ccp_pkg.sv ***
// shared constants and types of the two-unit capture/compare/pwm block
package ccp_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CCP_UNITS = 2;
  localparam int CCP_CTRL_W = 6;
  localparam int CCP_VALUE_W = 16;
  localparam int CCP_DUTY_W = 10;
  localparam int CCP_IDX_W = 8;

  // ****************************************
  // mode field codes
  // ****************************************
  localparam logic [3:0] CCP_MODE_OFF = 4'h0;
  localparam logic [3:0] CCP_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCP_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCP_MODE_CAP_DIV4 = 4'h6;
  localparam logic [3:0] CCP_MODE_CAP_DIV16 = 4'h7;
  localparam logic [3:0] CCP_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] CCP_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] CCP_MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] CCP_MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] CCP_GRP_CAPTURE = 2'b01;
  localparam logic [1:0] CCP_GRP_COMPARE = 2'b10;
  localparam logic [1:0] CCP_GRP_PWM = 2'b11;
  localparam logic [1:0] CCP_DIV4_LAST = 2'h3;
  localparam logic [3:0] CCP_DIV16_LAST = 4'hf;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_CTRL1 = 8'h17;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_CTRL2 = 8'h1d;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_VAL1_LO = 8'h15;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_VAL1_HI = 8'h16;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_VAL2_LO = 8'h1b;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_VAL2_HI = 8'h1c;
  localparam logic [CCP_IDX_W-1:0] CCP_IDX_FLAGS = 8'h0c;
  localparam int CCP_FLAG_POS1 = 2;
  localparam int CCP_FLAG_POS2 = 0;
  localparam logic [CCP_CTRL_W-1:0] CCP_CTRL_RESET = 6'h00;
  localparam logic [21:0] CCP_ADDR_HI_ZERO = 22'h00_0000;
  localparam logic [31:0] CCP_RDATA_ZERO = 32'h0000_0000;
  localparam logic [1:0] CCP_HRESP_OKAY = 2'h0;
  localparam logic [2:0] CCP_ARM_FULL = 3'h7;

  // ****************************************
  // carriers and state
  // ****************************************
  typedef struct packed {
    logic capture;
    logic event_hit;
    logic special;
  } ccp_evt_t;

  typedef struct packed {
    logic active;
    logic [CCP_DUTY_W-1:0] duty;
  } ccp_pwm_t;

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic prev;
    logic [2:0] armed;
    logic [3:0] presc;
    logic match_prev;
    logic cmp_out;
  } ccp_unit_state_t;

  typedef struct packed {
    logic [CCP_UNITS-1:0][CCP_CTRL_W-1:0] ctrl;
    logic [CCP_UNITS-1:0][CCP_VALUE_W-1:0] value;
    logic [CCP_UNITS-1:0] flag;
    logic wr_pend;
    logic [CCP_IDX_W-1:0] wr_idx;
    logic [31:0] rdata;
  } ccp_top_state_t;

endpackage

// *** logic/ccp_unit.sv ***
// one capture/compare engine: pin synchroniser, prescaler, compare match
`timescale 1ns/1ns
`default_nettype none
module ccp_unit
  import ccp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic capture_pin,
  input wire logic [3:0] unit_mode_field,
  input wire logic [CCP_VALUE_W-1:0] compare_value,
  input wire logic [CCP_VALUE_W-1:0] timer_one_count,
  output ccp_evt_t evt,
  output logic compare_out
);

  ccp_unit_state_t st_reg;
  ccp_unit_state_t st_next;
  logic rise;
  logic fall;
  logic is_capture;
  logic is_compare;
  logic match;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    evt = '0;
    // two flops before any edge logic looks at the pin
    st_next.sync_a = capture_pin;
    st_next.sync_b = st_reg.sync_a;
    st_next.prev = st_reg.sync_b;
    st_next.armed = {st_reg.armed[1:0], 1'b1};
    // edges only once prev holds a real sample, so reset is no edge
    rise = st_reg.armed[2] & st_reg.sync_b & ~st_reg.prev;
    fall = st_reg.armed[2] & ~st_reg.sync_b & st_reg.prev;
    is_capture = (unit_mode_field[3:2] == CCP_GRP_CAPTURE);
    is_compare = (unit_mode_field[3:2] == CCP_GRP_COMPARE);
    // counter runs on rising edges; not cleared between capture codes
    if (!is_capture) begin
      st_next.presc = '0;
    end else if (rise) begin
      st_next.presc = st_reg.presc + 4'h1;
    end
    case (unit_mode_field)
      CCP_MODE_CAP_FALL: begin
        evt.capture = fall;
      end
      CCP_MODE_CAP_RISE: begin
        evt.capture = rise;
      end
      CCP_MODE_CAP_DIV4: begin
        evt.capture = rise & (st_reg.presc[1:0] == CCP_DIV4_LAST);
      end
      CCP_MODE_CAP_DIV16: begin
        evt.capture = rise & (st_reg.presc == CCP_DIV16_LAST);
      end
      default: begin
        evt.capture = 1'b0;
      end
    endcase
    // match fires once when equality begins, not every cycle it lasts
    match = is_compare & (compare_value == timer_one_count);
    st_next.match_prev = match;
    evt.event_hit = evt.capture | (match & ~st_reg.match_prev);
    if (match & ~st_reg.match_prev) begin
      case (unit_mode_field)
        CCP_MODE_CMP_SET: begin
          st_next.cmp_out = 1'b1;
        end
        CCP_MODE_CMP_CLR: begin
          st_next.cmp_out = 1'b0;
        end
        CCP_MODE_CMP_SPECIAL: begin
          evt.special = 1'b1;
        end
        default: begin
          st_next.cmp_out = st_reg.cmp_out;
        end
      endcase
    end
    // mode off: everything but the synchroniser starts afresh
    if (unit_mode_field == CCP_MODE_OFF) begin
      st_next.presc = '0;
      st_next.match_prev = 1'b0;
      st_next.cmp_out = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign compare_out = st_reg.cmp_out;

endmodule
`default_nettype wire

// *** verification/ccp_top_properties.sv ***
// port assertions for ccp_top
`timescale 1ns/1ns
`default_nettype none
module ccp_top_properties
  import ccp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [CCP_VALUE_W-1:0] timer_one_count,
  input wire logic adc_enabled,
  input wire logic [CCP_UNITS-1:0] compare_out,
  input wire logic timer_one_reset,
  input wire logic adc_start,
  input wire ccp_pwm_t [CCP_UNITS-1:0] pwm
);
  logic wr_reg;
  logic rd_reg;
  logic [7:0] idx_reg;
  logic [1:0][5:0] ctrl_reg;
  wire logic take = hsel && hready && htrans[1] && haddr[31:10] == 22'h00_0000;
  wire logic [3:0] m0 = ctrl_reg[0][3:0];
  wire logic [3:0] m1 = ctrl_reg[1][3:0];
  // shadow of both control registers, so mode-dependent checks need no design internals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      idx_reg <= 8'h00;
      ctrl_reg <= '0;
    end else begin
      wr_reg <= take && hwrite;
      rd_reg <= take && !hwrite;
      idx_reg <= haddr[9:2];
      if (wr_reg && idx_reg == CCP_IDX_CTRL1) ctrl_reg[0] <= hwdata[5:0];
      if (wr_reg && idx_reg == CCP_IDX_CTRL2) ctrl_reg[1] <= hwdata[5:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pwm_active_one: assert property (pwm[0].active == (m0[3:2] == 2'b11)) else $error("pwm active");
  a_pwm_duty_lsb: assert property (pwm[1].active |-> pwm[1].duty[1:0] == ctrl_reg[1][5:4]) else $error("duty");
  a_ctrl_read_back: assert property (rd_reg && idx_reg == CCP_IDX_CTRL1 |-> hrdata == {26'h0, ctrl_reg[0]})
    else $error("ctrl read");
  a_off_clears_out: assert property ((m0 == 4'h0) [*2] |-> !compare_out[0]) else $error("off pin");
  a_set_needs_mode: assert property ($rose(compare_out[0]) |-> $past(m0) == CCP_MODE_CMP_SET) else $error("set");
  a_clear_needs_mode: assert property ($fell(compare_out[1]) |-> $past(m1) inside {4'h9, 4'h0}) else $error("clr");
  a_adc_start_cause: assert property (adc_start |-> timer_one_reset && adc_enabled && m1 == 4'hb) else $error("adc");
  a_trig_needs_mode: assert property (timer_one_reset |-> m0 == 4'hb || m1 == 4'hb) else $error("trig mode");
  a_trig_one_pulse: assert property (timer_one_reset ##1 $stable(timer_one_count) |-> !timer_one_reset)
    else $error("trig repeat");
endmodule
`default_nettype wire

// *** verification/ccp_pin_src.sv ***
// external signal source driving pulse trains onto the capture pins
`timescale 1ns/1ns
`default_nettype none
module ccp_pin_src (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [4:0] edges,
  input wire logic [2:0] half,
  output logic [1:0] capture_pin,
  output logic busy
);
  logic [4:0] left_reg;
  logic [3:0] ph_reg;
  wire logic [3:0] last = {half, 1'b0} - 4'h1;
  // train state; half sets a prompt or a slow pulse, never below two cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_reg <= 5'h00;
      ph_reg <= 4'h0;
    end else if (go && !busy) begin
      left_reg <= edges;
      ph_reg <= 4'h0;
    end else if (busy) begin
      ph_reg <= (ph_reg == last) ? 4'h0 : ph_reg + 4'h1;
      if (ph_reg == last) left_reg <= left_reg - 5'h01;
    end
  end
  assign busy = left_reg != 5'h00;
  // pin is a pure input to the block: high for half cycles, then low
  assign capture_pin = (busy && ph_reg < {1'b0, half}) ? sel : 2'b00;
endmodule
`default_nettype wire

// *** verification/test_ccp_mode_control_and_capture.sv ***
// self-checking bench for ccp_top
`timescale 1ns/1ns
`default_nettype none
module test_ccp_mode_control_and_capture
  import ccp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, adc_enabled, timer_one_reset, adc_start, go, busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp, capture_pin, compare_out, sel;
  logic [2:0] hsize, half;
  logic [4:0] edges;
  logic [15:0] timer_one_count, seed;
  ccp_pwm_t [1:0] pwm;
  int miscompares, checks_done;
  ccp_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .capture_pin(capture_pin), .timer_one_count(timer_one_count), .adc_enabled(adc_enabled),
    .compare_out(compare_out), .timer_one_reset(timer_one_reset), .adc_start(adc_start), .pwm(pwm));
  ccp_pin_src i_src (.hclk(hclk), .hresetn(hresetn), .go(go), .sel(sel), .edges(edges), .half(half),
    .capture_pin(capture_pin), .busy(busy));
  always #4 hclk = ~hclk;
  // lfsr keeps the random run repeatable
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [7:0] cidx(int u);
    return u ? CCP_IDX_CTRL2 : CCP_IDX_CTRL1;
  endfunction
  function automatic logic [7:0] vidx(int u, int hi);
    return u ? (hi ? CCP_IDX_VAL2_HI : CCP_IDX_VAL2_LO) : (hi ? CCP_IDX_VAL1_HI : CCP_IDX_VAL1_LO);
  endfunction
  function automatic logic [31:0] fbit(int u);
    return 32'h0000_0001 << (u ? CCP_FLAG_POS2 : CCP_FLAG_POS1);
  endfunction
  function automatic logic [31:0] pwm_exp(logic [31:0] d);
    return {21'h00_0000, 1'b1, d[7:0], d[9:8]};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // one single ahb transfer; waits on hready under a bound
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    rd = hrdata;
    if (n >= 64) begin miscompares++; finish_test(); end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {22'h00_0000, i, 2'b00}, d, x);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e, input string s);
    logic [31:0] x;
    bus(1'b0, {22'h00_0000, i, 2'b00}, 32'h0000_0000, x);
    chk(x, e, s);
    // the slave never refuses, so every answer must be okay
    chk({30'h0, hresp}, 32'h0000_0000, "resp");
  endtask
  task automatic pulses(input int u, input int n);
    int k;
    k = 0;
    sel <= 2'(1 << u);
    edges <= 5'(n);
    half <= 3'h2 + 3'(rnd() % 2);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do begin @(posedge hclk); k++; end while (busy === 1'b1 && k < 400);
    if (k >= 400) begin miscompares++; finish_test(); end
    repeat (6) @(posedge hclk);
  endtask
  initial begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    finish_test();
  end
  initial begin
    int u, m, n, k;
    logic [31:0] d, x;
    logic [15:0] t, c;
    logic [3:0] cm [6];
    logic e, o;
    // set, keep, clear, two triggers, set again: every pin move is visible
    cm = '{4'h8, 4'ha, 4'h9, 4'hb, 4'hb, 4'h8};
    {hclk, hresetn, hsel, hwrite, adc_enabled, go} = '0;
    {haddr, hwdata, htrans, sel, edges, timer_one_count, miscompares, checks_done} = '0;
    hsize = 3'h2;
    half = 3'h2;
    seed = 16'hb36e;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (u = 0; u < 2; u++) rdc(cidx(u), 32'h0000_0000, "ctrl reset");
    rdc(CCP_IDX_FLAGS, 32'h0000_0000, "flag reset");
    repeat (6) begin
      d[31:16] = rnd();
      d[15:0] = rnd();
      u = d[16];
      wr(cidx(u), d);
      rdc(cidx(u), {26'h000_0000, d[5:0]}, "ctrl rw");
    end
    wr(cidx(0), 32'h0000_0000);
    bus(1'b1, 32'h0000_045c, 32'h0000_003f, x);
    bus(1'b0, 32'h0000_045c, 32'h0000_0000, x);
    chk(x, 32'h0000_0000, "unmapped");
    rdc(cidx(0), 32'h0000_0000, "alias");
    $display("registers done");
    wr(cidx(1), 32'h0000_0000);
    for (u = 0; u < 2; u++) begin
      for (m = 4; m < 8; m++) begin
        n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
        wr(cidx(u), 32'h0000_0000);
        wr(cidx(u), 32'(m));
        wr(CCP_IDX_FLAGS, 32'h0000_0000);
        if (n > 1) pulses(u, n - 1);
        rdc(CCP_IDX_FLAGS, 32'h0000_0000, "early");
        timer_one_count <= rnd();
        pulses(u, 1);
        rdc(CCP_IDX_FLAGS, fbit(u), "cap flag");
        t = rnd();
        timer_one_count <= t;
        pulses(u, n);
        rdc(vidx(u, 0), {24'h00_0000, t[7:0]}, "cap low");
        rdc(vidx(u, 1), {24'h00_0000, t[15:8]}, "cap high");
      end
      wr(cidx(u), 32'h0000_0006);
      pulses(u, 2);
      wr(cidx(u), 32'h0000_0000);
      wr(cidx(u), 32'h0000_0006);
      wr(CCP_IDX_FLAGS, 32'h0000_0000);
      pulses(u, 3);
      rdc(CCP_IDX_FLAGS, 32'h0000_0000, "presc off");
      pulses(u, 1);
      rdc(CCP_IDX_FLAGS, fbit(u), "div4");
      wr(cidx(u), 32'h0000_0007);
      wr(CCP_IDX_FLAGS, 32'h0000_0000);
      pulses(u, 11);
      rdc(CCP_IDX_FLAGS, 32'h0000_0000, "presc kept");
      pulses(u, 1);
      rdc(CCP_IDX_FLAGS, fbit(u), "div16");
    end
    $display("capture done");
    for (u = 0; u < 2; u++) begin
      wr(cidx(u), 32'h0000_0000);
      c = rnd();
      wr(vidx(u, 0), {24'h00_0000, c[7:0]});
      wr(vidx(u, 1), {24'h00_0000, c[15:8]});
      o = 1'b0;
      for (k = 0; k < 6; k++) begin
        m = cm[k];
        timer_one_count <= c + 16'h0100;
        wr(cidx(u), 32'(m));
        wr(CCP_IDX_FLAGS, 32'h0000_0000);
        d = {16'h0000, rnd()};
        // the two trigger passes see the converter on, then off
        e = (m == 11) ? k[0] : d[0];
        adc_enabled <= e;
        timer_one_count <= c;
        @(negedge hclk);
        chk({30'h0, timer_one_reset, adc_start}, {30'h0, m == 11, m == 11 && u == 1 && e}, "trigger");
        @(posedge hclk);
        @(negedge hclk);
        o = (m == 8) ? 1'b1 : (m == 9) ? 1'b0 : o;
        if (m != 11) chk({31'h0, compare_out[u]}, {31'h0, o}, "cmp pin");
        @(posedge hclk);
        rdc(CCP_IDX_FLAGS, fbit(u), "cmp flag");
      end
      wr(cidx(u), 32'h0000_0000);
      @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, compare_out[u]}, 32'h0000_0000, "off pin");
      @(posedge hclk);
      d = {16'h0000, rnd()};
      wr(vidx(u, 0), {24'h00_0000, d[7:0]});
      wr(cidx(u), {26'h000_0000, d[9:8], 2'b11, d[11:10]});
      @(negedge hclk);
      chk(32'(pwm[u]), pwm_exp(d), "pwm");
      @(posedge hclk);
      wr(cidx(u), 32'h0000_0005);
      @(negedge hclk);
      chk({31'h0, pwm[u].active}, 32'h0000_0000, "pwm off");
      @(posedge hclk);
    end
    $display("compare and pwm done");
    finish_test();
  end
endmodule
bind ccp_top ccp_top_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .timer_one_count(timer_one_count), .adc_enabled(adc_enabled), .compare_out(compare_out),
  .timer_one_reset(timer_one_reset), .adc_start(adc_start), .pwm(pwm));
`default_nettype wire
